/* File: spps_pkg.sv */
// spps_pkg: constants and types shared by the streaming port packet sync block.
// assumes a 32-bit axi4-lite register bus and byte-wide internal buffer ports.
`default_nettype none

package spps_pkg;

  // bus and register map (byte addresses)
  localparam int SPPS_ADDR_W = 4;
  localparam logic [SPPS_ADDR_W-1:0] SPPS_CTRL_OFS = 4'h0;
  localparam logic [SPPS_ADDR_W-1:0] SPPS_LEN_OFS = 4'h4;
  localparam logic [SPPS_ADDR_W-1:0] SPPS_STAT_OFS = 4'h8;
  localparam logic [1:0] SPPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPPS_RESP_DECERR = 2'h3;

  // control register fields
  localparam int SPPS_CTL_SERIAL = 0;
  localparam int SPPS_CTL_MULTI = 1;
  localparam int SPPS_CTL_SYNC_LO = 2;
  localparam int SPPS_CTL_TXBUF_LO = 4;
  localparam int SPPS_CTL_RXBUF_LO = 7;
  localparam int SPPS_CTL_POL_EN = 10;
  localparam int SPPS_CTL_POL_SYNC = 11;
  localparam int SPPS_CTL_POL_AV = 12;
  localparam int SPPS_CTL_POL_DIR = 13;
  localparam int SPPS_CTL_TX_LE = 14;
  localparam int SPPS_CTL_RX_LE = 15;
  localparam int SPPS_CTL_ON = 16;
  localparam int SPPS_CTL_W = 17;
  localparam logic [SPPS_CTL_W-1:0] SPPS_CTRL_RESET = 17'h00000;

  // packet length field
  localparam int SPPS_LEN_W = 16;
  localparam logic [SPPS_LEN_W-1:0] SPPS_LEN_RESET = 16'h00bc;
  localparam logic [SPPS_LEN_W-1:0] SPPS_LEN_ONE = 16'h0001;

  // status register fields
  localparam int SPPS_STAT_RXLOAD = 16;
  localparam int SPPS_STAT_AV = 17;
  localparam int SPPS_STAT_INPKT = 18;

  // serial bit position
  localparam logic [2:0] SPPS_BIT_FIRST = 3'h0;
  localparam logic [2:0] SPPS_BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    SPPS_SYNC_COUNT = 2'b00,
    SPPS_SYNC_START = 2'b01,
    SPPS_SYNC_END = 2'b10,
    SPPS_SYNC_RSVD = 2'b11
  } spps_sync_type;

endpackage : spps_pkg

`default_nettype wire

/* File: spps_port.sv */
// spps_port: one streaming data port with packet framing and an axi4-lite slave.
// assumes the port pins and port clock are asynchronous to aclk and slower than aclk/4;
// the internal buffers sit on the user-side ports and answer within one aclk cycle.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module spps_port
  import spps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [spps_pkg::SPPS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spps_pkg::SPPS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins
  input wire logic port_clk,
  input wire logic [7:0] port_data_bus_in,
  output logic [7:0] port_data_bus_out,
  output logic [7:0] port_data_bus_oe,
  input wire logic packet_sync_marker_in,
  output logic packet_sync_marker_out,
  output logic packet_sync_marker_oe,
  input wire logic port_enable,
  input wire logic transfer_direction,
  input wire logic [2:0] buffer_select,
  output logic data_available,
  // transmit buffer side
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic [2:0] tx_buf,
  output logic [1:0] tx_lane,
  output logic tx_sop,
  output logic tx_eop,
  // receive buffer side
  output logic [2:0] rx_buf,
  output logic [1:0] rx_lane,
  input wire logic [7:0] rx_cell_ready,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_head_data,
  input wire logic rx_head_last,
  input wire logic rx_more,
  output logic rx_pop
);
  import spps_pkg::*;

  logic [SPPS_CTL_W-1:0] ctrl_q;
  logic [SPPS_LEN_W-1:0] len_q;
  logic [15:0] tx_pkts_q;

  // control fields
  logic cfg_serial, cfg_multi, cfg_on, cfg_tx_le, cfg_rx_le;
  logic [2:0] cfg_txbuf, cfg_rxbuf;
  spps_sync_type cfg_sync;
  assign cfg_serial = ctrl_q[SPPS_CTL_SERIAL];
  assign cfg_multi = ctrl_q[SPPS_CTL_MULTI];
  assign cfg_on = ctrl_q[SPPS_CTL_ON];
  assign cfg_tx_le = ctrl_q[SPPS_CTL_TX_LE];
  assign cfg_rx_le = ctrl_q[SPPS_CTL_RX_LE];
  assign cfg_txbuf = ctrl_q[SPPS_CTL_TXBUF_LO +: 3];
  assign cfg_rxbuf = ctrl_q[SPPS_CTL_RXBUF_LO +: 3];
  assign cfg_sync = spps_sync_type'(ctrl_q[SPPS_CTL_SYNC_LO +: 2]);

  // pin synchronisers: stage 1 is read only by stage 2
  logic [14:0] pin_s1_q, pin_s2_q;
  logic clk_s3_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      clk_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {port_clk, packet_sync_marker_in, port_enable, transfer_direction, buffer_select,
                   port_data_bus_in};
      pin_s2_q <= pin_s1_q;
      clk_s3_q <= pin_s2_q[14];
    end
  end

  logic port_rise, sync_act, en_act, dir_rx;
  logic [2:0] sel_s;
  logic [7:0] data_s;
  assign port_rise = pin_s2_q[14] & ~clk_s3_q;
  assign sync_act = pin_s2_q[13] ^ ctrl_q[SPPS_CTL_POL_SYNC];
  assign en_act = pin_s2_q[12] ^ ctrl_q[SPPS_CTL_POL_EN];
  assign dir_rx = pin_s2_q[11] ^ ctrl_q[SPPS_CTL_POL_DIR];
  assign sel_s = pin_s2_q[10:8];
  assign data_s = pin_s2_q[7:0];

  logic tx_run, rx_run;
  assign tx_run = cfg_on & ~dir_rx;
  assign rx_run = cfg_on & dir_rx;

  // ---------------- transmit: byte assembly ----------------
  logic [6:0] tx_sh_q;
  logic [2:0] tx_bit_q;
  logic tx_sync_seen_q;
  logic tx_byte_ok, tx_byte_sync;
  logic [7:0] tx_byte;
  logic ser_restart;
  // a start marker mid-byte realigns the bit counter
  assign ser_restart = (cfg_sync == SPPS_SYNC_START) & sync_act;

  always_comb begin
    tx_byte_ok = 1'b0;
    tx_byte = data_s;
    tx_byte_sync = sync_act;
    if (port_rise && tx_run && en_act) begin
      if (!cfg_serial) begin
        tx_byte_ok = 1'b1;
      end else begin
        tx_byte = {tx_sh_q, data_s[0]};
        tx_byte_sync = tx_sync_seen_q | sync_act;
        tx_byte_ok = (tx_bit_q == SPPS_BIT_LAST) & ~ser_restart;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_run || !cfg_serial) begin
      tx_sh_q <= '0;
      tx_bit_q <= SPPS_BIT_FIRST;
      tx_sync_seen_q <= 1'b0;
    end else if (port_rise && en_act) begin
      if (ser_restart) begin
        tx_sh_q <= {6'h00, data_s[0]};
        tx_bit_q <= SPPS_BIT_FIRST + 3'h1;
        tx_sync_seen_q <= 1'b1;
      end else begin
        tx_sh_q <= {tx_sh_q[5:0], data_s[0]};
        tx_bit_q <= tx_bit_q + 3'h1;
        tx_sync_seen_q <= (tx_bit_q == SPPS_BIT_LAST) ? 1'b0 : (tx_sync_seen_q | sync_act);
      end
    end
  end

  // ---------------- transmit: framing ----------------
  logic [SPPS_LEN_W-1:0] tx_cnt_q, tx_cnt_d;
  logic tx_take, tx_first, tx_last;
  logic tx_at_end;
  assign tx_at_end = (tx_cnt_q == len_q - SPPS_LEN_ONE);

  always_comb begin
    tx_take = 1'b0;
    tx_first = 1'b0;
    tx_last = 1'b0;
    tx_cnt_d = tx_cnt_q;
    if (tx_byte_ok) begin
      case (cfg_sync)
        SPPS_SYNC_START: begin
          if (tx_byte_sync) begin
            tx_take = 1'b1;
            tx_first = 1'b1;
            tx_last = (len_q == SPPS_LEN_ONE);
            tx_cnt_d = tx_last ? '0 : SPPS_LEN_ONE;
          end else if (tx_cnt_q != '0) begin
            tx_take = 1'b1;
            tx_last = tx_at_end;
            tx_cnt_d = tx_at_end ? '0 : tx_cnt_q + SPPS_LEN_ONE;
          end
        end
        SPPS_SYNC_END: begin
          tx_take = 1'b1;
          tx_first = (tx_cnt_q == '0);
          tx_last = tx_byte_sync;
          tx_cnt_d = tx_byte_sync ? '0 : tx_cnt_q + SPPS_LEN_ONE;
        end
        default: begin
          tx_take = 1'b1;
          tx_first = (tx_cnt_q == '0);
          tx_last = tx_at_end;
          tx_cnt_d = tx_at_end ? '0 : tx_cnt_q + SPPS_LEN_ONE;
        end
      endcase
    end
  end

  // counter restarts whenever the port is switched off, so it starts at enable
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_run) begin
      tx_cnt_q <= '0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_buf <= '0;
      tx_lane <= '0;
      tx_sop <= 1'b0;
      tx_eop <= 1'b0;
      tx_pkts_q <= '0;
    end else begin
      tx_valid <= tx_take;
      tx_sop <= tx_take & tx_first;
      tx_eop <= tx_take & tx_last;
      if (tx_take) begin
        tx_data <= tx_byte;
        tx_buf <= cfg_multi ? sel_s : cfg_txbuf;
        tx_lane <= cfg_tx_le ? tx_cnt_q[1:0] : ~tx_cnt_q[1:0];
      end
      if (tx_take && tx_last) begin
        tx_pkts_q <= tx_pkts_q + 16'h0001;
      end
    end
  end

  // ---------------- receive ----------------
  logic rx_loaded_q, rx_last_q, rx_first_q, av_int_q;
  logic [7:0] rx_byte_q;
  logic [2:0] rx_bit_q;
  logic [SPPS_LEN_W-1:0] rx_cnt_q;
  logic rx_avail, rx_step, rx_done, rx_load;
  logic rx_ld_last;

  assign rx_avail = rx_cell_ready[rx_buf] & rx_byte_valid;
  assign rx_step = port_rise & rx_run & rx_loaded_q & en_act;
  assign rx_done = rx_step & (~cfg_serial | (rx_bit_q == SPPS_BIT_LAST));
  assign rx_load = port_rise & rx_run & rx_avail & (~rx_loaded_q | rx_done);
  assign rx_ld_last = (cfg_sync == SPPS_SYNC_END) ? rx_head_last : (rx_cnt_q == len_q - SPPS_LEN_ONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf <= '0;
      rx_lane <= '0;
    end else begin
      rx_buf <= cfg_multi ? sel_s : cfg_rxbuf;
      rx_lane <= cfg_rx_le ? rx_cnt_q[1:0] : ~rx_cnt_q[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_loaded_q <= 1'b0;
      rx_last_q <= 1'b0;
      rx_first_q <= 1'b0;
      rx_byte_q <= '0;
      rx_bit_q <= SPPS_BIT_FIRST;
      rx_cnt_q <= '0;
      av_int_q <= 1'b0;
      rx_pop <= 1'b0;
    end else begin
      rx_pop <= rx_load;
      if (rx_load) begin
        rx_loaded_q <= 1'b1;
        rx_byte_q <= rx_head_data;
        rx_bit_q <= SPPS_BIT_FIRST;
        rx_first_q <= (rx_cnt_q == '0);
        rx_last_q <= rx_ld_last;
        rx_cnt_q <= rx_ld_last ? '0 : rx_cnt_q + SPPS_LEN_ONE;
        av_int_q <= ~(rx_ld_last & ~rx_more);
      end else if (rx_done) begin
        rx_loaded_q <= 1'b0;
        av_int_q <= 1'b0;
      end else if (rx_step) begin
        rx_byte_q <= {rx_byte_q[6:0], 1'b0}; // msb first
        rx_bit_q <= rx_bit_q + 3'h1;
      end
    end
  end

  // pin drivers follow the loaded byte; data lines change on load or step, and clear when receive stops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_data_bus_out <= '0;
      port_data_bus_oe <= '0;
      packet_sync_marker_out <= 1'b0;
      packet_sync_marker_oe <= 1'b0;
      data_available <= 1'b0;
    end else begin
      port_data_bus_oe <= rx_run ? (cfg_serial ? 8'h01 : 8'hff) : 8'h00;
      port_data_bus_out <= cfg_serial ? {7'h00, rx_byte_q[7]} : rx_byte_q;
      packet_sync_marker_oe <= rx_run & (cfg_sync == SPPS_SYNC_START | cfg_sync == SPPS_SYNC_END);
      packet_sync_marker_out <= ctrl_q[SPPS_CTL_POL_SYNC] ^ (rx_loaded_q &
        ((cfg_sync == SPPS_SYNC_START) ? rx_first_q : rx_last_q));
      data_available <= ctrl_q[SPPS_CTL_POL_AV] ^ av_int_q;
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic aw_full_q, w_full_q;
  logic [SPPS_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] ctrl_wr, len_wr;

  function automatic logic [31:0] spps_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : spps_merge

  assign ctrl_wr = spps_merge({15'h0000, ctrl_q}, w_data_q, w_strb_q);
  assign len_wr = spps_merge({16'h0000, len_q}, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SPPS_RESP_OKAY;
      ctrl_q <= SPPS_CTRL_RESET;
      len_q <= SPPS_LEN_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_q && w_full_q && !s_axi_bvalid) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= SPPS_RESP_OKAY;
        case (aw_addr_q)
          SPPS_CTRL_OFS: ctrl_q <= ctrl_wr[SPPS_CTL_W-1:0];
          SPPS_LEN_OFS: len_q <= len_wr[SPPS_LEN_W-1:0];
          SPPS_STAT_OFS: s_axi_bresp <= SPPS_RESP_OKAY;
          default: s_axi_bresp <= SPPS_RESP_DECERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SPPS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SPPS_RESP_OKAY;
        case (s_axi_araddr)
          SPPS_CTRL_OFS: s_axi_rdata <= {15'h0000, ctrl_q};
          SPPS_LEN_OFS: s_axi_rdata <= {16'h0000, len_q};
          SPPS_STAT_OFS: begin
            s_axi_rdata <= '0;
            s_axi_rdata[15:0] <= tx_pkts_q;
            s_axi_rdata[SPPS_STAT_RXLOAD] <= rx_loaded_q;
            s_axi_rdata[SPPS_STAT_AV] <= av_int_q;
            s_axi_rdata[SPPS_STAT_INPKT] <= (tx_cnt_q != '0);
          end
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= SPPS_RESP_DECERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------- assertions ----------------
  AST_TX_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
    (port_rise && tx_run && !en_act) |=> (!tx_valid && $stable(tx_cnt_q)))
    else $error("transmit byte taken or counter moved with enable inactive");

  AST_TX_FIXED_BUF: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_take && !cfg_multi) |=> (tx_buf == $past(cfg_txbuf)))
    else $error("single-stream transmit went to a buffer other than the configured one");

  AST_TX_COUNT_END: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_byte_ok && cfg_sync == SPPS_SYNC_COUNT && tx_cnt_q == len_q - SPPS_LEN_ONE)
    |=> (tx_eop && tx_valid) ##1 (tx_cnt_q == '0 || !tx_run))
    else $error("counter-only packet not ended at configured length");

  AST_TX_START_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_byte_ok && cfg_sync == SPPS_SYNC_START && !tx_byte_sync && tx_cnt_q == '0) |=> !tx_valid)
    else $error("byte outside a start-marked packet written to buffer");

  AST_RX_AV_WITH_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(av_int_q) |-> (rx_loaded_q ##1 (port_data_bus_oe != 8'h00)))
    else $error("data-available rose without a byte presented");

  AST_RX_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_loaded_q && rx_run && !(port_rise && en_act) && $stable(ctrl_q)) |=> $stable(rx_byte_q))
    else $error("receive byte changed while stalled");

  AST_RX_AV_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_load && rx_ld_last && !rx_more) |=> (!av_int_q && rx_loaded_q))
    else $error("data-available not dropped with last byte of drained packet");

  AST_SYNC_HIZ_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_sync == SPPS_SYNC_COUNT) |=> !packet_sync_marker_oe)
    else $error("sync marker driven in counter-only mode");

  AST_SERIAL_ONE_LINE: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_serial |=> (port_data_bus_oe[7:1] == 7'h00))
    else $error("serial mode drives more than data line zero");

endmodule : spps_port

`default_nettype wire

/* File: spps_stream_src.sv */
// spps_stream_src: behavioural stream source at the far side of the port pins.
// assumes the port samples its pins on the rising edge of the port clock.
`timescale 1ns/1ns
`default_nettype none

module spps_stream_src (
  // port pins driven by the source
  output var logic port_clk,
  output var logic [7:0] port_data_bus_in,
  output var logic packet_sync_marker_in,
  output var logic port_enable,
  output var logic transfer_direction,
  output var logic [2:0] buffer_select
);

  initial begin
    port_clk = 1'b0;
    port_data_bus_in = 8'h00;
    packet_sync_marker_in = 1'b0;
    port_enable = 1'b0;
    transfer_direction = 1'b0;
    buffer_select = 3'h0;
  end

  // one unit per port clock; the clock stands still between units
  task automatic put_byte(input logic [7:0] b, input logic s, input logic en, input logic [2:0] a);
    begin
      // non-blocking so pins never race the aclk sampling edge they fall on
      port_data_bus_in <= b;
      packet_sync_marker_in <= s;
      port_enable <= en;
      buffer_select <= a;
      #80;
      port_clk <= 1'b1;
      #40;
      // released data and sync lines show the inverse and enable drops, so stale values never pass for data
      port_data_bus_in <= ~b;
      packet_sync_marker_in <= ~s;
      port_enable <= 1'b0;
      #40;
      port_clk <= 1'b0;
    end
  endtask : put_byte

  task automatic set_dir(input logic d);
    transfer_direction <= d;
  endtask : set_dir

endmodule : spps_stream_src

`default_nettype wire

/* File: spps_port_tb_top.sv */
// spps_port_tb_top: self-checking bench for the streaming port registers, transmit framing and counter-only receive.
// assumes the source model drives the pins; a small head model stands in for the receive buffer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module spps_port_tb_top;
  import spps_pkg::*;

  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, port_clk, packet_sync_marker_in;
  logic packet_sync_marker_out, packet_sync_marker_oe, port_enable, transfer_direction, data_available;
  logic tx_valid, tx_sop, tx_eop, rx_pop, rx_byte_valid, rx_head_last, rx_more;
  logic [SPPS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_lane, rx_lane;
  logic [7:0] port_data_bus_in, port_data_bus_out, port_data_bus_oe, tx_data, rx_cell_ready, rx_head_data;
  logic [2:0] buffer_select, tx_buf, rx_buf;
  logic [12:0] txq[$];
  int err_count = 0;
  int num_checks = 0;

  spps_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_clk, .port_data_bus_in,
    .port_data_bus_out, .port_data_bus_oe, .packet_sync_marker_in, .packet_sync_marker_out, .packet_sync_marker_oe,
    .port_enable, .transfer_direction, .buffer_select, .data_available, .tx_valid, .tx_data, .tx_buf, .tx_lane,
    .tx_sop, .tx_eop, .rx_buf, .rx_lane, .rx_cell_ready, .rx_byte_valid, .rx_head_data, .rx_head_last, .rx_more,
    .rx_pop);

  spps_stream_src u_src (.port_clk, .port_data_bus_in, .packet_sync_marker_in, .port_enable, .transfer_direction,
    .buffer_select);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // every byte handed to the transmit buffer: {buffer, first, last, data}
  always @(posedge aclk) if (tx_valid === 1'b1) txq.push_back({tx_buf, tx_sop, tx_eop, tx_data});

  // receive buffer model: the head byte advances by one on each pop
  int num_pops = 0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_head_data <= 8'h5a;
    end else if (rx_pop === 1'b1) begin
      rx_head_data <= rx_head_data + 8'h01;
      num_pops++;
    end
  end

  task automatic give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask : give_verdict

  task automatic timed_out(input int n);
    begin
      if (n >= 60) begin
        err_count++;
        $display("MISMATCH wait exp done got timeout");
        give_verdict();
      end
    end
  endtask : timed_out

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 60; n++) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      timed_out(n);
      `CHK("bresp", r, s_axi_bresp)
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 60; n++) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      timed_out(n);
      `CHK("rresp", r, s_axi_rresp)
      `CHK("rdata", d, s_axi_rdata)
    end
  endtask : axi_rd

  // port off first so every scenario starts with cleared byte counters
  task automatic set_cfg(input logic [31:0] c);
    begin
      axi_wr(SPPS_CTRL_OFS, 32'h0, SPPS_RESP_OKAY);
      axi_wr(SPPS_CTRL_OFS, c, SPPS_RESP_OKAY);
    end
  endtask : set_cfg

  task automatic pop_tx(input logic [12:0] e);
    logic [12:0] g;
    int n;
    begin
      for (n = 0; n < 60 && txq.size() == 0; n++) @(posedge aclk);
      timed_out(n);
      g = txq.pop_front();
      `CHK("tx_byte", e, g)
    end
  endtask : pop_tx

  task automatic no_more_tx(input string name);
    begin
      repeat (20) @(posedge aclk);
      `CHK("tx_extra", 0, txq.size())
      $display("test %s done", name);
    end
  endtask : no_more_tx

  task automatic t_regs;
    begin
      axi_rd(SPPS_CTRL_OFS, 32'h0, SPPS_RESP_OKAY);
      axi_rd(SPPS_LEN_OFS, {16'h0, SPPS_LEN_RESET}, SPPS_RESP_OKAY);
      axi_wr(SPPS_LEN_OFS, 32'h4, SPPS_RESP_OKAY);
      axi_rd(SPPS_LEN_OFS, 32'h4, SPPS_RESP_OKAY);
      axi_wr(4'hc, 32'h1, SPPS_RESP_DECERR);
      axi_rd(4'hc, 32'h0, SPPS_RESP_DECERR);
      `CHK("avail", 1'b0, data_available)
      $display("test regs done");
    end
  endtask : t_regs

  task automatic t_count;
    begin
      set_cfg(32'h1 << SPPS_CTL_ON | 32'h2 << SPPS_CTL_TXBUF_LO);
      u_src.put_byte(8'h76, 1'b1, 1'b1, 3'h5);
      u_src.put_byte(8'ha9, 1'b0, 1'b1, 3'h5);
      u_src.put_byte(8'h55, 1'b1, 1'b0, 3'h5);
      u_src.put_byte(8'h1e, 1'b0, 1'b1, 3'h5);
      u_src.put_byte(8'h03, 1'b0, 1'b1, 3'h5);
      u_src.put_byte(8'hff, 1'b0, 1'b1, 3'h5);
      pop_tx({3'h2, 1'b1, 1'b0, 8'h76});
      pop_tx({3'h2, 1'b0, 1'b0, 8'ha9});
      pop_tx({3'h2, 1'b0, 1'b0, 8'h1e});
      pop_tx({3'h2, 1'b0, 1'b1, 8'h03});
      pop_tx({3'h2, 1'b1, 1'b0, 8'hff});
      axi_rd(SPPS_STAT_OFS, 32'h1 << SPPS_STAT_INPKT | 32'h1, SPPS_RESP_OKAY);
      `CHK("sync_oe", 1'b0, packet_sync_marker_oe)
      `CHK("data_oe", 8'h00, port_data_bus_oe)
      no_more_tx("count");
    end
  endtask : t_count

  task automatic t_serial;
    logic [7:0] b;
    int i;
    begin
      b = 8'ha5;
      set_cfg(32'h1 << SPPS_CTL_ON | 32'h1 << SPPS_CTL_SERIAL);
      for (i = 7; i >= 0; i--) u_src.put_byte({7'h55, b[i]}, 1'b0, 1'b1, 3'h0);
      pop_tx({3'h0, 1'b1, 1'b0, 8'ha5});
      no_more_tx("serial");
    end
  endtask : t_serial

  task automatic t_start;
    begin
      set_cfg(32'h1 << SPPS_CTL_ON | 32'h1 << SPPS_CTL_SYNC_LO | 32'h1 << SPPS_CTL_MULTI);
      u_src.put_byte(8'h11, 1'b0, 1'b1, 3'h3);
      u_src.put_byte(8'h76, 1'b1, 1'b1, 3'h3);
      u_src.put_byte(8'ha9, 1'b0, 1'b1, 3'h3);
      u_src.put_byte(8'h1e, 1'b0, 1'b1, 3'h3);
      u_src.put_byte(8'h03, 1'b0, 1'b1, 3'h3);
      u_src.put_byte(8'h44, 1'b0, 1'b1, 3'h6);
      u_src.put_byte(8'hff, 1'b1, 1'b1, 3'h6);
      pop_tx({3'h3, 1'b1, 1'b0, 8'h76});
      pop_tx({3'h3, 1'b0, 1'b0, 8'ha9});
      pop_tx({3'h3, 1'b0, 1'b0, 8'h1e});
      pop_tx({3'h3, 1'b0, 1'b1, 8'h03});
      pop_tx({3'h6, 1'b1, 1'b0, 8'hff});
      no_more_tx("start");
    end
  endtask : t_start

  task automatic t_end;
    begin
      set_cfg(32'h1 << SPPS_CTL_ON | 32'h2 << SPPS_CTL_SYNC_LO);
      u_src.put_byte(8'h47, 1'b0, 1'b1, 3'h0);
      u_src.put_byte(8'h3f, 1'b1, 1'b1, 3'h0);
      u_src.put_byte(8'h76, 1'b0, 1'b1, 3'h0);
      u_src.put_byte(8'h12, 1'b0, 1'b1, 3'h0);
      u_src.put_byte(8'h56, 1'b1, 1'b1, 3'h0);
      pop_tx({3'h0, 1'b1, 1'b0, 8'h47});
      pop_tx({3'h0, 1'b0, 1'b1, 8'h3f});
      pop_tx({3'h0, 1'b1, 1'b0, 8'h76});
      pop_tx({3'h0, 1'b0, 1'b0, 8'h12});
      pop_tx({3'h0, 1'b0, 1'b1, 8'h56});
      no_more_tx("end");
    end
  endtask : t_end

  // counter-only receive, length two: present, stall, then last byte with nothing behind it
  task automatic t_recv;
    begin
      u_src.set_dir(1'b1);
      axi_wr(SPPS_LEN_OFS, 32'h2, SPPS_RESP_OKAY);
      set_cfg(32'h1 << SPPS_CTL_ON);
      rx_cell_ready <= 8'h01;
      {rx_byte_valid, rx_more} <= 2'h3;
      u_src.put_byte(8'h00, 1'b0, 1'b0, 3'h5);
      `CHK("rx_av", 1'b1, data_available)
      `CHK("rx_data", 8'h5a, port_data_bus_out)
      `CHK("rx_buf", 3'h0, rx_buf)
      `CHK("rx_lane", 2'h2, rx_lane)
      u_src.put_byte(8'h00, 1'b0, 1'b0, 3'h5);
      `CHK("rx_hold", 8'h5a, port_data_bus_out)
      rx_more <= 1'b0;
      u_src.put_byte(8'h00, 1'b0, 1'b1, 3'h5);
      `CHK("rx_last", 8'h5b, port_data_bus_out)
      `CHK("rx_av_drop", 1'b0, data_available)
      `CHK("rx_data_oe", 8'hff, port_data_bus_oe)
      `CHK("rx_sync_oe", 1'b0, packet_sync_marker_oe)
      `CHK("rx_pops", 2, num_pops)
      rx_byte_valid <= 1'b0;
      $display("test recv done");
    end
  endtask : t_recv

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rx_cell_ready = 8'h00;
    {rx_byte_valid, rx_head_last, rx_more} = 3'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_count();
    t_serial();
    t_start();
    t_end();
    t_recv();
    give_verdict();
  end

endmodule : spps_port_tb_top

`default_nettype wire
